// >>> logic/rss_map.svh
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_CLK_HZ         250000000
`define RSS_PUT_TIME_MS    64
`define RSS_PUT_CYCLES     ((`RSS_PUT_TIME_MS) * (`RSS_CLK_HZ / 1000))
`define RSS_FILT_TIME_NS   100
`define RSS_FILT_CYCLES    ((`RSS_FILT_TIME_NS + 3) / 4)
`define RSS_MODE_ON        2'h3
`define RSS_MODE_SLEEP_OFF 2'h2
`define RSS_MODE_SW        2'h1
`define RSS_MODE_OFF       2'h0
`endif

// >>> logic/rss_pkg.sv
package rss_pkg;
  typedef logic [1:0] rss_mode_t;
  typedef enum logic [1:0] {
    RSS_HOLD,
    RSS_WAIT_RDY,
    RSS_TIMER,
    RSS_RUN
  } rss_state_t;
endpackage : rss_pkg

// >>> logic/rss_counter.sv
`timescale 1ns/1ps
module rss_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  done
);
  logic [WIDTH-1:0] count;
  initial begin
    if (WIDTH < 2) $error("width too small");
  end
  // counts run cycles up to limit, then holds done
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count <= '0;
      done  <= 1'b0;
    end else if (run && !done) begin
      if (count + WIDTH'(1) >= limit) begin
        done <= 1'b1;
      end
      count <= count + WIDTH'(1);
    end
  end
endmodule : rss_counter

// >>> logic/rss_filter.sv
`timescale 1ns/1ps
module rss_filter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             below,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  trip
);
  logic [WIDTH-1:0] count;
  initial begin
    if (WIDTH < 1) $error("width too small");
  end
  // trips only once the supply stays low past the limit
  always_ff @(posedge clk) begin
    if (!rst_n || !enable || !below) begin
      count <= '0;
      trip  <= 1'b0;
    end else if (count >= limit) begin
      trip <= 1'b1;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule : rss_filter

// >>> logic/rss_supervisor.sv
`timescale 1ns/1ps
`include "rss_map.svh"
// Function
// - hold core reset while power-on detector reports low supply
// - power-up timer gives 64 ms delay after power-on or brown-out
// - core stays in reset while power-up timer runs
// - timer enabled when enable_n bit clear, bypassed when set
// - timer starts only after power-on and brown-out both released
// - active protection holds reset while supply at or below threshold
// - mode 11: detector always on, start waits ready, wake not delayed
// - mode 10: off in sleep; start and wake wait for ready
// - mode 01: software enable switches detector; start not delayed
// - mode 00: detector off, start immediate, ready held low
// - software mode: protection once ready; readiness shown on ready
// - software mode: sleep does not change protection
// - brown-out resets only after supply stays low past filter time
// - one level-select bit picks the brown-out threshold
// - forced-on mode adds no wake delay; ready set no later than core release
module rss_supervisor #(
  parameter int PUT_CYCLES  = `RSS_PUT_CYCLES,
  parameter int FILT_CYCLES = `RSS_FILT_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               supply_ok,
  input  wire logic               below_low_level,
  input  wire logic               below_high_level,
  input  wire logic               detector_ready,
  input  wire logic               power_up_timer_enable_n,
  input  wire rss_pkg::rss_mode_t brownout_mode_sel,
  input  wire logic               brownout_level_sel,
  input  wire logic               sw_brownout_enable,
  input  wire logic               sleep,
  output logic                    core_reset_n,
  output logic                    brownout_ready,
  output logic                    detector_on,
  output logic                    brownout_reset
);
  import rss_pkg::*;

  localparam int CW = $clog2(PUT_CYCLES + 1) + 1;
  localparam int FW = $clog2(FILT_CYCLES + 1) + 1;

  initial begin
    if (PUT_CYCLES < 1) $error("timer count too small");
    if (FILT_CYCLES < 1) $error("filter count too small");
  end

  rss_state_t state;
  rss_state_t next_state;
  logic       next_det_on;
  logic       prot_active;
  logic       below_sel;
  logic       bor_trip;
  logic       timer_done;
  logic       timer_run;
  logic       timer_clear;
  logic       por_or_bor;
  logic       wake_wait;
  logic       sleep_d;

  function automatic logic det_enabled(input rss_mode_t m,
                                       input logic s,
                                       input logic sw);
    unique case (m)
      `RSS_MODE_ON:        det_enabled = 1'b1;
      `RSS_MODE_SLEEP_OFF: det_enabled = !s;
      `RSS_MODE_SW:        det_enabled = sw;
      `RSS_MODE_OFF:       det_enabled = 1'b0;
    endcase
  endfunction : det_enabled

  function automatic logic start_waits(input rss_mode_t m);
    start_waits = (m == `RSS_MODE_ON) || (m == `RSS_MODE_SLEEP_OFF);
  endfunction : start_waits

  always_comb begin
    next_det_on = det_enabled(brownout_mode_sel, sleep, sw_brownout_enable);
  end

  // detector enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detector_on <= 1'b0;
    end else begin
      detector_on <= next_det_on;
    end
  end

  // protection counts only once the detector is ready
  assign prot_active = detector_on && detector_ready;
  assign below_sel   = brownout_level_sel ? below_high_level
                                          : below_low_level;

  rss_filter #(
    .WIDTH (FW)
  ) u_filter (
    .clk    (clk),
    .rst_n  (rst_n),
    .below  (below_sel),
    .enable (prot_active),
    .limit  (FW'(FILT_CYCLES)),
    .trip   (bor_trip)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brownout_reset <= 1'b0;
    end else begin
      brownout_reset <= bor_trip;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brownout_ready <= 1'b0;
    end else begin
      brownout_ready <= detector_on && detector_ready;
    end
  end

  assign por_or_bor = !supply_ok || bor_trip;
  assign timer_clear = por_or_bor;
  assign timer_run   = (state == RSS_TIMER);

  rss_counter #(
    .WIDTH (CW)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (timer_clear),
    .run   (timer_run),
    .limit (CW'(PUT_CYCLES)),
    .done  (timer_done)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_d <= 1'b0;
    end else begin
      sleep_d <= sleep;
    end
  end

  // wake from sleep in mode 10 waits for the detector
  assign wake_wait = sleep_d && !sleep
                     && (brownout_mode_sel == `RSS_MODE_SLEEP_OFF)
                     && !detector_ready;

  always_comb begin
    next_state = state;
    unique case (state)
      RSS_HOLD: begin
        if (!por_or_bor) begin
          next_state = RSS_WAIT_RDY;
        end
      end
      RSS_WAIT_RDY: begin
        if (por_or_bor) begin
          next_state = RSS_HOLD;
        end else if (!start_waits(brownout_mode_sel)
                     || (detector_ready && detector_on
                         && !below_sel)) begin
          next_state = power_up_timer_enable_n ? RSS_RUN
                                               : RSS_TIMER;
        end
      end
      RSS_TIMER: begin
        if (por_or_bor) begin
          next_state = RSS_HOLD;
        end else if (timer_done) begin
          next_state = RSS_RUN;
        end
      end
      RSS_RUN: begin
        if (por_or_bor) begin
          next_state = RSS_HOLD;
        end else if (wake_wait) begin
          next_state = RSS_WAIT_RDY;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= RSS_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // core released only from run state, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= (next_state == RSS_RUN) && !por_or_bor;
    end
  end
endmodule : rss_supervisor

// >>> bench/rss_chk_sva.sv
`timescale 1ns/1ps
module rss_chk
  import rss_pkg::*;
#(
  parameter int PUT_CYCLES  = 20,
  parameter int FILT_CYCLES = 3
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               supply_ok,
  input wire logic               below_low_level,
  input wire logic               below_high_level,
  input wire logic               power_up_timer_enable_n,
  input wire rss_pkg::rss_mode_t brownout_mode_sel,
  input wire logic               brownout_level_sel,
  input wire logic               sw_brownout_enable,
  input wire logic               sleep,
  input wire logic               core_reset_n,
  input wire logic               brownout_ready,
  input wire logic               detector_on,
  input wire logic               brownout_reset
);
  int low_cnt;
  int hold_cnt;
  always_ff @(posedge clk) begin
    low_cnt <= (brownout_level_sel ? below_high_level : below_low_level)
               ? low_cnt + 1 : 0;
  end
  always_ff @(posedge clk) begin
    hold_cnt <= core_reset_n ? 0 : hold_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_por_hold: assert property (!supply_ok |=> !core_reset_n)
    else $error("core out of reset on low supply");
  chk_bor_hold: assert property (brownout_reset |-> !core_reset_n)
    else $error("core out of reset on brown-out");
  chk_mode_off: assert property (brownout_mode_sel == 2'h0 |=> !detector_on)
    else $error("detector on in off mode");
  chk_mode_sw: assert property (brownout_mode_sel == 2'h1 |=>
    detector_on == $past(sw_brownout_enable)) else $error("sw mode");
  chk_mode_sleep: assert property (brownout_mode_sel == 2'h2 |=>
    detector_on == !$past(sleep)) else $error("sleep mode");
  chk_ready_off: assert property (!detector_on [*2] |-> !brownout_ready)
    else $error("ready while detector off");
  chk_filter_len: assert property ($rose(brownout_reset) |->
    $past(low_cnt) >= FILT_CYCLES) else $error("filter too short");
  chk_timer_len: assert property ($rose(core_reset_n) &&
    !power_up_timer_enable_n |-> $past(hold_cnt) >= PUT_CYCLES)
    else $error("timer too short");
  chk_release_ok: assert property ($rose(core_reset_n) |->
    $past(supply_ok) && !$past(brownout_reset)) else $error("bad release");
endmodule : rss_chk
bind rss_supervisor rss_chk #(.PUT_CYCLES(PUT_CYCLES),
  .FILT_CYCLES(FILT_CYCLES)) u_chk (.*);

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rss_pkg::*;
  logic      clk, rst_n, supply_ok, below_low_level, below_high_level;
  logic      detector_ready, power_up_timer_enable_n, brownout_level_sel;
  logic      sw_brownout_enable, sleep, core_reset_n, brownout_ready;
  logic      detector_on, brownout_reset;
  rss_mode_t brownout_mode_sel;
  int        error_cnt, n_compared, cyc, n;
  rss_supervisor #(.PUT_CYCLES(20), .FILT_CYCLES(3)) dut (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic boot(input rss_mode_t m, input logic en_n, input logic rdy);
    brownout_mode_sel = m;
    power_up_timer_enable_n = en_n;
    detector_ready = rdy;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
  endtask : boot
  task automatic wait_rel(input int lim);
    n = 0;
    while (core_reset_n !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_rel
  initial begin
    {supply_ok, below_low_level, below_high_level} = '0;
    {brownout_level_sel, sw_brownout_enable, sleep} = '0;
    boot(2'h0, 1'b1, 1'b0);
    tick(8);
    chk(core_reset_n, 1'b0);
    supply_ok = 1'b1;
    wait_rel(6);
    chk(core_reset_n, 1'b1);
    boot(2'h0, 1'b0, 1'b0);
    wait_rel(60);
    chk(n >= 20, 1'b1);
    chk(core_reset_n, 1'b1);
    boot(2'h3, 1'b1, 1'b0);
    tick(10);
    chk(core_reset_n, 1'b0);
    detector_ready = 1'b1;
    wait_rel(6);
    chk(core_reset_n, 1'b1);
    chk(brownout_ready, 1'b1);
    sleep = 1'b1;
    below_low_level = 1'b1;
    tick(2);
    below_low_level = 1'b0;
    tick(4);
    chk(core_reset_n, 1'b1);
    brownout_level_sel = 1'b1;
    below_low_level = 1'b1;
    tick(8);
    chk(core_reset_n, 1'b1);
    below_high_level = 1'b1;
    tick(8);
    chk(brownout_reset, 1'b1);
    chk(core_reset_n, 1'b0);
    {below_low_level, below_high_level, sleep} = '0;
    boot(2'h1, 1'b1, 1'b0);
    wait_rel(6);
    chk(core_reset_n, 1'b1);
    chk(detector_on, 1'b0);
    sw_brownout_enable = 1'b1;
    tick(2);
    chk(brownout_ready, 1'b0);
    detector_ready = 1'b1;
    tick(2);
    chk(brownout_ready, 1'b1);
    sleep = 1'b1;
    tick(2);
    chk(detector_on, 1'b1);
    sleep = 1'b0;
    boot(2'h2, 1'b1, 1'b1);
    wait_rel(8);
    sleep = 1'b1;
    detector_ready = 1'b0;
    tick(2);
    chk(detector_on, 1'b0);
    sleep = 1'b0;
    tick(6);
    chk(core_reset_n, 1'b0);
    detector_ready = 1'b1;
    wait_rel(8);
    chk(core_reset_n, 1'b1);
    finish_test();
  end
endmodule : testbench
